// ---- sim/loop_sink.sv ----
// loop-side command sink that stalls at random
`timescale 1ns/1ps
module loop_sink (
  input wire logic clk_in,
  input wire logic valid_in,
  input wire logic [23:0] data_in,
  output logic ready_out,
  output int n_out,
  output logic [23:0] last_out
);
  int seed = 7;
  initial
  begin
    ready_out = 1'b0;
    n_out = 0;
    last_out = 24'h000000;
  end
  // stalls keep a command waiting in the queue
  always @(negedge clk_in)
    ready_out <= $random(seed) % 2 != 0;
  always @(posedge clk_in)
    if (valid_in && ready_out)
    begin
      n_out <= n_out + 1;
      last_out <= data_in;
    end
endmodule // loop_sink

// ---- sim/modbus_slave_request_handler_tb.sv ----
// self-checking bench of the modbus slave request handler
`timescale 1ns/1ps
module modbus_slave_request_handler_tb;
  logic clk_in, rst_n_in, req_valid_in, req_ready_out, req_intact_in;
  logic req_len_ok_in, req_tcp_in, wdata_valid_in, wdata_ready_out;
  logic resp_valid_out, resp_ready_in, resp_last_out, station_avail_in;
  logic left_known_in, left_main_in, left_alarm_in, right_known_in;
  logic right_main_in, right_alarm_in, cmd_valid_out, cmd_ready_in;
  logic cmd_is_reg_out, cmd_select_out, cmd_pulse_out;
  logic [7:0] req_slave_in, req_func_in, resp_func_out, resp_code_out;
  logic [7:0] slave_addr_in;
  logic [15:0] req_addr_in, req_count_in, req_value_in, wdata_in, v;
  logic [15:0] resp_data_out, filter_window_in, cmd_data_out;
  logic [23:0] last_cmd;
  logic [31:0] unit_online_in, alarm_src_in, al;
  logic [4:0] cmd_unit_out;
  logic [63:0] local_coils_out;
  logic [5:0] s;
  logic [15:0] hold_model [16];
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 15573;
  int cycles = 0;
  int n_cmd, a, k;
  modbus_slave_request_handler #(.TICK_CYCLES(4)) i_dut (.*);
  loop_sink i_sink (.clk_in, .valid_in(cmd_valid_out),
    .data_in({cmd_is_reg_out, cmd_select_out, cmd_pulse_out, cmd_unit_out,
    cmd_data_out}), .ready_out(cmd_ready_in), .n_out(n_cmd),
    .last_out(last_cmd));
  always #2 clk_in = ~clk_in;
  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one request, returns mid-cycle while the reply beat stands
  task automatic req(input logic [7:0] f, input logic [15:0] ad, va, n);
    int w;
    w = 0;
    @(negedge clk_in);
    {req_func_in, req_addr_in, req_value_in, req_count_in} = {f, ad, va, n};
    req_valid_in = 1'b1;
    do @(posedge clk_in); while (req_ready_out !== 1'b1 && ++w < 50);
    @(negedge clk_in);
    req_valid_in = 1'b0;
    while (resp_valid_out !== 1'b1 && ++w < 99) @(negedge clk_in);
  endtask
  task automatic resp(input logic [7:0] f, c, input logic [15:0] d);
    check("func", {8'h00, resp_func_out}, {8'h00, f});
    check("code", {8'h00, resp_code_out}, {8'h00, c});
    check("data", resp_data_out, d);
    check("last", {15'h0000, resp_last_out}, 16'h0001);
  endtask
  // one write data word, held until taken
  task automatic wd(input logic [15:0] d);
    @(negedge clk_in);
    {wdata_valid_in, wdata_in} = {1'b1, d};
    do @(posedge clk_in); while (wdata_ready_out !== 1'b1);
    @(negedge clk_in);
    wdata_valid_in = 1'b0;
  endtask
  function automatic logic [7:0] side(input logic [2:0] b);
    return !b[2] ? 8'h00 : !b[1] ? 8'h01 : b[0] ? 8'h03 : 8'h04;
  endfunction
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard well above the expected run length
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    clk_in = 1'b0;
    {rst_n_in, req_valid_in, req_tcp_in, wdata_valid_in} = 4'h0;
    {req_slave_in, req_func_in, req_addr_in, req_count_in} = 48'h0;
    {req_value_in, wdata_in, s} = 38'h0;
    {left_known_in, left_main_in, left_alarm_in} = 3'h0;
    {right_known_in, right_main_in, right_alarm_in} = 3'h0;
    {req_intact_in, req_len_ok_in, resp_ready_in, station_avail_in} = 4'hF;
    slave_addr_in = 8'h11;
    filter_window_in = 16'h0064;
    unit_online_in = 32'hFFFFFFFB;
    al = $random(seed);
    alarm_src_in = al;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    for (k = 0; k < 4; k++)
    begin
      a = $random(seed) & 15;
      v = $random(seed);
      hold_model[a] = v;
      req(8'h06, a[15:0], v, 16'h0001);
      resp(8'h06, 8'h00, v);
      req(8'h03, a[15:0], 16'h0000, 16'h0001);
      resp(8'h03, 8'h00, hold_model[a]);
    end
    req(8'h07, 16'h0000, 16'h0000, 16'h0001);
    resp(8'h87, 8'h01, 16'h0000);
    req(8'h03, 16'h0100, 16'h0000, 16'h0001);
    resp(8'h83, 8'h02, 16'h0000);
    req(8'h03, 16'h0000, 16'h0000, 16'h0000);
    resp(8'h83, 8'h03, 16'h0000);
    v = $random(seed);
    req(8'h08, 16'h0000, v, 16'h0000);
    resp(8'h08, 8'h00, v);
    for (k = 0; k < 6; k++)
    begin
      @(negedge clk_in);
      s = $random(seed);
      {left_known_in, left_main_in, left_alarm_in} = s[5:3];
      {right_known_in, right_main_in, right_alarm_in} = s[2:0];
      req(8'h08, 16'h0002, 16'h0000, 16'h0000);
      resp(8'h08, 8'h00, {side(s[5:3]), side(s[2:0])});
    end
    station_avail_in = 1'b0;
    req(8'h03, 16'h0000, 16'h0000, 16'h0001);
    resp(8'h83, 8'h0A, 16'h0000);
    station_avail_in = 1'b1;
    req_len_ok_in = 1'b0;
    req(8'h03, 16'h0000, 16'h0000, 16'h0001);
    resp(8'h83, 8'h01, 16'h0000);
    {req_len_ok_in, req_tcp_in, req_slave_in} = 10'h312;
    req(8'h03, 16'h0000, 16'h0000, 16'h0001);
    resp(8'h83, 8'h0A, 16'h0000);
    req_tcp_in = 1'b0;
    req(8'h10, 16'h0040, 16'h0000, 16'h007C);
    resp(8'h90, 8'h02, 16'h0000);
    // field coil: reply first, command afterwards, repeat filtered
    req(8'h05, 16'h0040, 16'h1234, 16'h0000);
    check("cmdv", {15'h0, cmd_valid_out}, 16'h0000);
    repeat (40) @(posedge clk_in);
    check("ncmd", 16'(n_cmd), 16'h0001);
    check("cmd", last_cmd[15:0], 16'hFF00);
    check("kind", {8'h00, last_cmd[23:16]}, 16'h0020);
    req(8'h05, 16'h0040, 16'h1234, 16'h0000);
    repeat (40) @(posedge clk_in);
    check("ncmd", 16'(n_cmd), 16'h0001);
    req(8'h05, 16'h0044, 16'hFF00, 16'h0000);
    resp(8'h85, 8'h0A, 16'h0000);
    // two field registers in one multiple write
    v = $random(seed);
    fork
      req(8'h10, 16'h0010, 16'h0000, 16'h0002);
      begin
        wd(v);
        wd(~v);
      end
    join
    resp(8'h10, 8'h00, 16'h0002);
    repeat (40) @(posedge clk_in); // pace writes
    check("ncmd", 16'(n_cmd), 16'h0003);
    check("cmd", last_cmd[15:0], ~v);
    check("kind", {8'h00, last_cmd[23:16]}, 16'h0081);
    @(negedge clk_in);
    alarm_src_in = 32'h00000000;
    req(8'h02, 16'h0000, 16'h0000, 16'h0010);
    resp(8'h02, 8'h00, al[15:0]);
    req(8'h05, 16'h001F, 16'hFF00, 16'h0000);
    resp(8'h05, 8'h00, 16'hFF00);
    repeat (2) @(negedge clk_in);
    req(8'h04, 16'h0000, 16'h0000, 16'h0001);
    resp(8'h04, 8'h00, 16'h0000);
    req(8'h04, 16'h0001, 16'h0000, 16'h0001);
    resp(8'h04, 8'h00, al[31:16]);
    req(8'h05, 16'h0003, 16'h0005, 16'h0000);
    repeat (2) @(negedge clk_in);
    check("coil", {15'h0, local_coils_out[3]}, 16'h0001);
    wrap_up();
  end
endmodule // modbus_slave_request_handler_tb

// ---- verilog/cmd_queue.sv ----
// queue of field-unit commands waiting for the current loop
`timescale 1ns/1ps
module cmd_queue #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 128
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic push_valid_in,
  output logic push_ready_out,
  input wire logic [WIDTH-1:0] push_data_in,
  output logic pop_valid_out,
  input wire logic pop_ready_in,
  output logic [WIDTH-1:0] pop_data_out,
  output logic [$clog2(DEPTH+1)-1:0] free_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("queue depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } q_t;
  q_t q_q;
  q_t q_d;
  logic push;
  logic pop;

  // handshakes; full refuses pushes so the writer stalls
  assign push_ready_out = q_q.cnt != CW'(DEPTH);
  assign pop_valid_out = q_q.cnt != '0;
  assign push = push_valid_in && push_ready_out;
  assign pop = pop_ready_in && pop_valid_out;
  assign pop_data_out = q_q.mem[q_q.rp];
  assign free_out = CW'(DEPTH) - q_q.cnt;

  // next state
  always_comb
  begin
    q_d = q_q;
    if (push)
    begin
      q_d.mem[q_q.wp] = push_data_in;
      q_d.wp = q_q.wp + 1'b1;
    end
    if (pop)
      q_d.rp = q_q.rp + 1'b1;
    if (push && !pop)
      q_d.cnt = q_q.cnt + 1'b1;
    else if (pop && !push)
      q_d.cnt = q_q.cnt - 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      q_q <= '0;
    else
      q_q <= q_d;
  end

  a_count_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    q_q.cnt <= CW'(DEPTH)) else $error("queue count above depth");
endmodule // cmd_queue

// ---- verilog/mbs_pkg.sv ----
// shared constants and types of the modbus slave request handler
//
// Behaviour
// - a write to a station-owned coil or register stores the data there
// - a write to a field-unit coil or register becomes a loop command
// - single field write: take request, send reply, then send the command
// - normal reply needs intact request, right length, and for a single field write its unit online
// - drop a command repeating the last one to that unit within the window
// - diagnostic function supports sub-code 00 echo, plus the side word only
// - side word: low byte right, high byte left; 0,1,3,4 state codes
// - multiple writes of up to 123 items are queued for the loop
// - exception 01 for unsupported function or wrong message length
// - exception 02 for bad address or multiple write count above limit
// - exception 03 for an illegal value in the query data
// - exception 06 when queue space cannot hold the whole write
// - exception 0A when unavailable or TCP slave address mismatches
// - functions 01/05/15 coils, 02 inputs, 04 input, 03/06/16 holding
// - holding register reads return the last value written
// - listed numbers start at 1, wire addresses at 0
// - field alarms latch; host reads, then writes accept coil 32
// - every field coil write is sent as a pulse command
// - coil value 0000 is off, any non-zero value is on
// - latch clears only after read, then accept, then source normal
package mbs_pkg;
  // function codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  // exception codes
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_VALUE = 8'h03;
  localparam logic [7:0] EX_BUSY = 8'h06;
  localparam logic [7:0] EX_UNAVAIL = 8'h0A;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  // diagnostic sub-codes and side states
  localparam logic [15:0] DIAG_ECHO = 16'h0000;
  localparam logic [15:0] DIAG_SIDES = 16'h0002;
  localparam logic [7:0] SIDE_UNKNOWN = 8'h00;
  localparam logic [7:0] SIDE_BACKUP = 8'h01;
  localparam logic [7:0] SIDE_MAIN_ALARM = 8'h03;
  localparam logic [7:0] SIDE_MAIN_OK = 8'h04;
  // address map and limits
  localparam int MAX_WRITE_ITEMS = 123;
  localparam int LOCAL_COILS = 64;
  localparam int LOCAL_HREGS = 16;
  localparam int LISTED_BASE = 1;
  localparam int ACCEPT_COIL_NUM = 32;
  // wire address is listed number less one
  localparam logic [15:0] ACCEPT_COIL_ADDR = 16'(ACCEPT_COIL_NUM - LISTED_BASE);
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // filter time base
  localparam int TICK_TIME_US = 1000;
  localparam int CLK_MHZ = 250;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
  // request handler states
  typedef enum logic [1:0] {ST_IDLE, ST_RESP, ST_WRITE, ST_PUSH} state_t;
endpackage

// ---- verilog/modbus_slave_request_handler.sv ----
// modbus slave request decoder, local store, alarm latch and command feed
`timescale 1ns/1ps
module modbus_slave_request_handler #(
  parameter int UNITS = 32,
  parameter int QDEPTH = 128,
  parameter int TICK_CYCLES = mbs_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic req_intact_in,
  input wire logic req_len_ok_in,
  input wire logic req_tcp_in,
  input wire logic [7:0] req_slave_in,
  input wire logic [7:0] req_func_in,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_count_in,
  input wire logic [15:0] req_value_in,
  input wire logic wdata_valid_in,
  output logic wdata_ready_out,
  input wire logic [15:0] wdata_in,
  output logic resp_valid_out,
  input wire logic resp_ready_in,
  output logic [7:0] resp_func_out,
  output logic [7:0] resp_code_out,
  output logic [15:0] resp_data_out,
  output logic resp_last_out,
  input wire logic [7:0] slave_addr_in,
  input wire logic station_avail_in,
  input wire logic [UNITS-1:0] unit_online_in,
  input wire logic [UNITS-1:0] alarm_src_in,
  input wire logic [15:0] filter_window_in,
  input wire logic left_known_in,
  input wire logic left_main_in,
  input wire logic left_alarm_in,
  input wire logic right_known_in,
  input wire logic right_main_in,
  input wire logic right_alarm_in,
  output logic cmd_valid_out,
  input wire logic cmd_ready_in,
  output logic [$clog2(UNITS)-1:0] cmd_unit_out,
  output logic cmd_is_reg_out,
  output logic cmd_select_out,
  output logic cmd_pulse_out,
  output logic [15:0] cmd_data_out,
  output logic [mbs_pkg::LOCAL_COILS-1:0] local_coils_out
);
  localparam int LC = mbs_pkg::LOCAL_COILS;
  localparam int LH = mbs_pkg::LOCAL_HREGS;
  localparam int NH = LH + UNITS;
  localparam int NW = UNITS / 16;
  localparam int UW = $clog2(UNITS);
  localparam int HW = $clog2(NH);
  localparam int LCW = $clog2(LC);
  localparam int QW = 18 + UW;
  localparam int CW = $clog2(QDEPTH+1);

  if (UNITS < 16 || UNITS % 16 != 0 || QDEPTH < mbs_pkg::MAX_WRITE_ITEMS)
  begin : g_bad_params
    $error("units must be a multiple of 16, queue at least 123 deep");
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    mbs_pkg::state_t st;
    logic [7:0] func;
    logic [7:0] rfunc;
    logic [7:0] code;
    logic [15:0] addr;
    logic [15:0] cnt;
    logic [15:0] idx;
    logic [15:0] value;
    logic [15:0] word;
    logic have;
    logic [15:0] rdata;
    logic last;
    logic [LC-1:0] coils;
    logic [NH-1:0][15:0] hreg;
    logic [UNITS-1:0] latch;
    logic [UNITS-1:0] seen;
    logic [UNITS-1:0] acc;
    logic [UNITS-1:0] fresh;
    logic [UNITS-1:0] prv;
    logic [UNITS-1:0] flt_v;
    logic [UNITS-1:0][17:0] flt_key;
    logic [UNITS-1:0][15:0] flt_at;
    logic [31:0] tick;
    logic [15:0] now;
  } st_t;
  st_t s;
  st_t n;

  logic [QW-1:0] q_data;
  logic push_v;
  logic q_ready;
  logic [CW-1:0] q_free;
  logic [15:0] base;
  logic [15:0] end_a;
  logic [15:0] ba;
  logic [15:0] rword;
  logic [UNITS-1:0] rmask;
  logic [7:0] fn;
  logic bitrd;
  logic last_w;
  logic [7:0] exc;
  logic [15:0] cnt1;
  logic single;
  logic [15:0] ia;
  logic [15:0] ival;
  logic [15:0] cdata;
  logic is_reg;
  logic loc;
  logic [UW-1:0] unit;
  logic [17:0] key;
  logic dup;
  logic item_act;
  logic item_done;
  logic need_w;
  logic acc_ev;

  function automatic logic [7:0] side_code(input logic known,
    input logic main, input logic alarm);
    if (!known)
      return mbs_pkg::SIDE_UNKNOWN;
    if (!main)
      return mbs_pkg::SIDE_BACKUP;
    return alarm ? mbs_pkg::SIDE_MAIN_ALARM : mbs_pkg::SIDE_MAIN_OK;
  endfunction

  // wire address to field unit, wire address taken 0-based
  function automatic logic [UW-1:0] unit_of(input logic reg_t,
    input logic [15:0] a);
    logic [15:0] o;
    o = reg_t ? a - 16'(LH) : a - 16'(LC);
    return reg_t ? o[UW-1:0] : o[UW:1];
  endfunction

  function automatic logic is_local(input logic reg_t, input logic [15:0] a);
    return reg_t ? a < 16'(LH) : a < 16'(LC);
  endfunction

  assign req_ready_out = s.st == mbs_pkg::ST_IDLE;
  assign resp_valid_out = s.st == mbs_pkg::ST_RESP;
  assign resp_func_out = s.rfunc;
  assign resp_code_out = s.code;
  assign resp_data_out = s.rdata;
  assign resp_last_out = s.last;
  assign local_coils_out = s.coils;

  // ****************************************************************
  // decode and sequencing
  // ****************************************************************
  always_comb
  begin
    n = s;
    ba = 16'h0000;
    rword = 16'h0000;
    rmask = '0;
    wdata_ready_out = 1'b0;
    push_v = 1'b0;
    item_done = 1'b0;
    acc_ev = 1'b0;
    // read window: first word from the request, later from the running base
    fn = (s.st == mbs_pkg::ST_IDLE) ? req_func_in : s.func;
    bitrd = fn == mbs_pkg::FC_RD_COILS || fn == mbs_pkg::FC_RD_DISC;
    if (s.st == mbs_pkg::ST_IDLE)
    begin
      base = req_addr_in;
      end_a = req_addr_in + req_count_in;
    end
    else
    begin
      base = s.addr + (bitrd ? 16'h0010 : 16'h0001);
      end_a = s.value;
    end
    last_w = {1'b0, base} + (bitrd ? 17'h00010 : 17'h00001) >= {1'b0, end_a};
    for (int b = 0; b < 16; b++)
    begin
      ba = base + 16'(b);
      if (ba < end_a && fn == mbs_pkg::FC_RD_COILS && ba < 16'(LC))
        rword[b] = s.coils[ba[LCW-1:0]];
      if (ba < end_a && fn == mbs_pkg::FC_RD_DISC && ba < 16'(UNITS))
      begin
        rword[b] = s.latch[ba[UW-1:0]];
        rmask[ba[UW-1:0]] = 1'b1;
      end
    end
    // holding reads give last written value
    if (fn == mbs_pkg::FC_RD_HOLD && base < 16'(NH))
      rword = s.hreg[base[HW-1:0]];
    for (int w = 0; w < NW; w++)
    begin
      if (fn == mbs_pkg::FC_RD_INREG && base == 16'(w))
      begin
        rword = s.latch[16*w +: 16];
        rmask[16*w +: 16] = 16'hFFFF;
      end
      if (fn == mbs_pkg::FC_RD_INREG && base == 16'(NW + w))
        rword = s.fresh[16*w +: 16];
    end

    // request checks, in priority order
    single = req_func_in == mbs_pkg::FC_WR_COIL ||
      req_func_in == mbs_pkg::FC_WR_REG;
    cnt1 = single ? 16'h0001 : req_count_in;
    exc = mbs_pkg::EX_NONE;
    if (!station_avail_in || (req_tcp_in && req_slave_in != slave_addr_in))
      exc = mbs_pkg::EX_UNAVAIL;
    else if (!req_len_ok_in || !(req_func_in inside {mbs_pkg::FC_RD_COILS,
      mbs_pkg::FC_RD_DISC, mbs_pkg::FC_RD_HOLD, mbs_pkg::FC_RD_INREG,
      mbs_pkg::FC_WR_COIL, mbs_pkg::FC_WR_REG, mbs_pkg::FC_DIAG,
      mbs_pkg::FC_WR_COILS, mbs_pkg::FC_WR_REGS}))
      exc = mbs_pkg::EX_FUNC;
    // only echo and side word sub-codes
    else if (req_func_in == mbs_pkg::FC_DIAG)
    begin
      if (req_addr_in != mbs_pkg::DIAG_ECHO &&
        req_addr_in != mbs_pkg::DIAG_SIDES)
        exc = mbs_pkg::EX_VALUE;
    end
    else if (cnt1 > 16'(mbs_pkg::MAX_WRITE_ITEMS) || {1'b0, req_addr_in} +
      {1'b0, cnt1} > 17'(req_func_in == mbs_pkg::FC_RD_DISC ? UNITS :
      req_func_in == mbs_pkg::FC_RD_INREG ? 2 * NW :
      bitrd || req_func_in == mbs_pkg::FC_WR_COIL ||
      req_func_in == mbs_pkg::FC_WR_COILS ? LC + 2 * UNITS : NH))
      exc = mbs_pkg::EX_ADDR;
    // zero count is an illegal value
    else if (cnt1 == 16'h0000)
      exc = mbs_pkg::EX_VALUE;
    // whole write must fit the queue
    else if ((req_func_in == mbs_pkg::FC_WR_COILS ||
      req_func_in == mbs_pkg::FC_WR_REGS || single) &&
      16'(q_free) < cnt1)
      exc = mbs_pkg::EX_BUSY;
    // single field write needs its unit online
    else if (single && !is_local(req_func_in == mbs_pkg::FC_WR_REG,
      req_addr_in) && !unit_online_in[unit_of(req_func_in ==
      mbs_pkg::FC_WR_REG, req_addr_in)])
      exc = mbs_pkg::EX_UNAVAIL;

    // write item decode, shared by single and multiple writes
    is_reg = s.func == mbs_pkg::FC_WR_REG || s.func == mbs_pkg::FC_WR_REGS;
    ia = s.addr + s.idx;
    need_w = is_reg || s.idx[3:0] == 4'h0;
    if (s.st == mbs_pkg::ST_PUSH)
      ival = s.value;
    else if (is_reg)
      ival = s.word;
    else
      ival = {15'h0000, s.word[s.idx[3:0]]};
    loc = is_local(is_reg, ia);
    unit = unit_of(is_reg, ia);
    // zero is off, anything else on
    cdata = is_reg ? ival : (ival != 16'h0000 ? mbs_pkg::COIL_ON :
      mbs_pkg::COIL_OFF);
    key = {is_reg, !is_reg && ia[0], cdata};
    dup = s.flt_v[unit] && s.flt_key[unit] == key &&
      16'(s.now - s.flt_at[unit]) < filter_window_in;
    item_act = s.st == mbs_pkg::ST_PUSH ||
      (s.st == mbs_pkg::ST_WRITE && !(need_w && !s.have));
    if (item_act)
    begin
      // every holding write is kept for readback
      if (is_reg && ia < 16'(NH))
        n.hreg[ia[HW-1:0]] = ival;
      if (loc)
      begin
        // station coils and registers stored directly
        if (!is_reg)
          n.coils[ia[LCW-1:0]] = ival != 16'h0000;
        acc_ev = !is_reg && ia == mbs_pkg::ACCEPT_COIL_ADDR &&
          ival != 16'h0000;
        item_done = 1'b1;
      end
      else if (dup || !unit_online_in[unit])
        item_done = 1'b1;
      else
      begin
        // field write becomes a loop command
        push_v = 1'b1;
        // a full queue stalls the writer
        item_done = q_ready;
        if (q_ready)
        begin
          n.flt_v[unit] = 1'b1;
          n.flt_key[unit] = key;
          n.flt_at[unit] = s.now;
        end
      end
    end

    unique case (s.st)
      mbs_pkg::ST_IDLE:
      begin
        // damaged requests are dropped without a reply
        if (req_valid_in && req_intact_in)
        begin
          n.func = req_func_in;
          n.addr = req_addr_in;
          n.cnt = cnt1;
          n.idx = 16'h0000;
          n.have = 1'b0;
          n.value = req_value_in;
          n.code = exc;
          n.last = 1'b1;
          n.rdata = req_value_in;
          n.rfunc = req_func_in;
          n.st = mbs_pkg::ST_RESP;
          if (exc != mbs_pkg::EX_NONE)
          begin
            n.rfunc = req_func_in | mbs_pkg::EXC_FLAG;
            n.rdata = 16'h0000;
          end
          else if (req_func_in inside {mbs_pkg::FC_RD_COILS,
            mbs_pkg::FC_RD_DISC, mbs_pkg::FC_RD_HOLD, mbs_pkg::FC_RD_INREG})
          begin
            n.rdata = rword;
            n.value = end_a;
            n.last = last_w;
            n.seen = s.seen | (rmask & s.latch);
          end
          else if (req_func_in == mbs_pkg::FC_DIAG &&
            req_addr_in == mbs_pkg::DIAG_SIDES)
            n.rdata = {side_code(left_known_in, left_main_in, left_alarm_in),
              side_code(right_known_in, right_main_in, right_alarm_in)};
          // multiple write collects its items first
          else if (req_func_in == mbs_pkg::FC_WR_COILS ||
            req_func_in == mbs_pkg::FC_WR_REGS)
          begin
            n.rdata = req_count_in;
            n.st = mbs_pkg::ST_WRITE;
          end
        end
      end
      mbs_pkg::ST_RESP:
      begin
        if (resp_ready_in)
        begin
          if (!s.last)
          begin
            n.addr = base;
            n.rdata = rword;
            n.last = last_w;
            n.seen = s.seen | (rmask & s.latch);
          end
          // reply goes out before the single write is issued
          else if (s.code == mbs_pkg::EX_NONE && (s.func ==
            mbs_pkg::FC_WR_COIL || s.func == mbs_pkg::FC_WR_REG))
            n.st = mbs_pkg::ST_PUSH;
          else
            n.st = mbs_pkg::ST_IDLE;
        end
      end
      mbs_pkg::ST_WRITE:
      begin
        if (need_w && !s.have)
        begin
          wdata_ready_out = 1'b1;
          n.word = wdata_in;
          n.have = wdata_valid_in;
        end
        else if (item_done)
        begin
          n.idx = s.idx + 16'h0001;
          n.have = !(is_reg || s.idx[3:0] == 4'hF);
          if (s.idx + 16'h0001 == s.cnt)
            n.st = mbs_pkg::ST_RESP;
        end
      end
      mbs_pkg::ST_PUSH:
      begin
        if (item_done)
          n.st = mbs_pkg::ST_IDLE;
      end
    endcase

    // filter time base in ticks
    if (s.tick == 32'(TICK_CYCLES - 1))
    begin
      n.tick = 32'h00000000;
      n.now = s.now + 16'h0001;
    end
    else
      n.tick = s.tick + 32'h00000001;

    // alarms latch; source set wins over clear
    n.prv = alarm_src_in;
    n.fresh = (s.fresh & ~{UNITS{acc_ev}}) | (alarm_src_in & ~s.prv);
    // clear needs read, then accept, then source normal
    n.acc = (n.acc | (acc_ev ? n.seen & s.latch : '0)) &
      ~(s.acc & ~alarm_src_in);
    n.seen = n.seen & ~(s.acc & ~alarm_src_in);
    n.latch = (s.latch & ~(s.acc & ~alarm_src_in)) | alarm_src_in;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= n;
  end

  // ****************************************************************
  // command queue
  // ****************************************************************
  assign q_data = {key[17], key[16], unit, key[15:0]};
  cmd_queue #(.WIDTH(QW), .DEPTH(QDEPTH)) u_queue (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .push_valid_in(push_v),
    .push_ready_out(q_ready),
    .push_data_in(q_data),
    .pop_valid_out(cmd_valid_out),
    .pop_ready_in(cmd_ready_in),
    .pop_data_out({cmd_is_reg_out, cmd_select_out, cmd_unit_out,
      cmd_data_out}),
    .free_out(q_free)
  );
  // coil commands always go out as pulses
  assign cmd_pulse_out = !cmd_is_reg_out;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  a_exc_reply_form: assert property (
    resp_valid_out && resp_code_out != 8'h00 |->
    resp_func_out[7] && resp_data_out == 16'h0000)
    else $error("exception reply badly formed");
  a_bad_length: assert property (
    req_ready_out && req_valid_in && req_intact_in && station_avail_in &&
    !req_tcp_in && !req_len_ok_in |=>
    resp_valid_out && resp_code_out == 8'h01)
    else $error("bad length not answered with 01");
  a_tcp_slave: assert property (
    req_ready_out && req_valid_in && req_intact_in && req_tcp_in &&
    req_slave_in != slave_addr_in |=> resp_code_out == 8'h0A)
    else $error("foreign slave address not answered with 0A");
  a_multi_cap: assert property (
    req_ready_out && req_valid_in && req_intact_in && station_avail_in &&
    !req_tcp_in && req_len_ok_in && req_func_in == 8'h10 &&
    req_count_in > 16'd123 |=> resp_code_out == 8'h02)
    else $error("oversized multiple write not answered with 02");
  a_reply_first: assert property (
    $rose(s.st == mbs_pkg::ST_PUSH) |->
    $past(resp_valid_out && resp_ready_in))
    else $error("single write issued before its reply");
  a_alarm_latch: assert property (
    alarm_src_in[0] |=> s.latch[0] [*2] or (s.latch[0] ##1 1'b1))
    else $error("alarm not latched");
  a_accept_read: assert property (
    s.latch[0] && !s.seen[0] && !s.acc[0] |=> s.latch[0])
    else $error("unread alarm cleared");
  a_dup_drop: assert property (
    item_act && !loc && dup |-> !push_v)
    else $error("duplicate command forwarded");

  c_exception: cover property (resp_valid_out && resp_code_out != 8'h00);
  c_multi_done: cover property (s.st == mbs_pkg::ST_WRITE ##1
    s.st == mbs_pkg::ST_RESP);
  c_dup: cover property (item_act && dup && !loc);
  c_alarm_clear: cover property ($fell(s.latch[0]));
endmodule // modbus_slave_request_handler
